//--- core/vpqm_pkg.sv
// Package with register map, field layout and types for the priority queue mapper
package vpqm_pkg;
    localparam logic [7:0] VPQM_ADDR_MAP_LOW = 8'h80;
    localparam logic [7:0] VPQM_ADDR_MAP_HIGH = 8'h81;
    localparam logic [7:0] VPQM_ADDR_FOLD = 8'h82;
    localparam logic [7:0] VPQM_RST_MAP_LOW = 8'h50;
    localparam logic [7:0] VPQM_RST_MAP_HIGH = 8'hfa;
    localparam logic [1:0] VPQM_RST_SPLIT = 2'h2;
    localparam logic [1:0] VPQM_RST_FOLD_RSVD_HI = 2'h0;
    localparam logic [1:0] VPQM_RST_FOLD_RSVD_MID = 2'h1;
    localparam logic [1:0] VPQM_RST_FOLD_RSVD_TOP = 2'h0;
    localparam int VPQM_SPLIT_LSB = 6;
    localparam int VPQM_FIELD_W = 2;
    localparam int VPQM_PCP_COUNT = 8;
    localparam logic [7:0] VPQM_RDATA_NONE = 8'h00;
    localparam logic [1:0] VPQM_Q_LOWEST = 2'h0;
    localparam logic [1:0] VPQM_Q_HIGHEST = 2'h3;
    localparam logic [1:0] VPQM_Q_MID_LOW = 2'h1;
    localparam logic [1:0] VPQM_Q_MID_HIGH = 2'h2;

    typedef struct packed {
        logic valid;
        logic use_dscp;
        logic [2:0] pcp;
        logic [1:0] dscp_queue;
    } vpqm_req_t;

    typedef struct packed {
        logic valid;
        logic [1:0] queue;
        logic two_q_high;
    } vpqm_res_t;
endpackage

//--- core/vpqm_mapper.sv
// Priority to egress queue mapper with its three control registers
// Function
// - Tagged frame's queue is the 2-bit field selected by its 3-bit priority
// - Queue 3 is highest, queue 0 lowest, four queues 0 to 3
// - Priorities 0-3 in first register, 4-7 in second, two bits each ascending
// - Reset maps 0,1 to 0; 2,3 to 1; 4,5 to 2; 6,7 to 3
// - Fold to low/high only in two-queue mode, source 802.1p or DiffServ
// - In two-queue mode result 0 goes low, result 3 goes high
// - Result 1 follows split bit 0, result 2 follows split bit 1
module vpqm_mapper
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic two_queue_mode,
    input vpqm_pkg::vpqm_req_t req,
    output vpqm_pkg::vpqm_res_t res
);

////////////////////////////////////////////////////////////////////////////////
// Registers and internal signals
logic [7:0] map_low_r;
logic [7:0] map_high_r;
logic [1:0] two_queue_split_select_r;
logic [7:0] reg_rdata_nxt;
logic [7:0] reg_rdata_r;
logic sel_map_low;
logic sel_map_high;
logic sel_fold;
logic wr_map_low;
logic wr_map_high;
logic wr_fold;
logic [15:0] map_all;
logic [1:0] pcp_queue_field [vpqm_pkg::VPQM_PCP_COUNT];
logic [1:0] mapped;
logic fold_high;
vpqm_pkg::vpqm_res_t res_nxt;
logic res_valid_r;
logic [1:0] res_queue_r;
logic res_high_r;

////////////////////////////////////////////////////////////////////////////////
// Address decode
assign sel_map_low = (reg_addr == vpqm_pkg::VPQM_ADDR_MAP_LOW);
assign sel_map_high = (reg_addr == vpqm_pkg::VPQM_ADDR_MAP_HIGH);
assign sel_fold = (reg_addr == vpqm_pkg::VPQM_ADDR_FOLD);
assign wr_map_low = reg_wr & sel_map_low;
assign wr_map_high = reg_wr & sel_map_high;
assign wr_fold = reg_wr & sel_fold;

////////////////////////////////////////////////////////////////////////////////
// Map fields for priorities 0 to 3
always_ff @(posedge clock)
begin
    if (!rst_n)
    begin
        map_low_r <= vpqm_pkg::VPQM_RST_MAP_LOW;
    end
    else if (wr_map_low)
    begin
        map_low_r <= reg_wdata;
    end
end

// Map fields for priorities 4 to 7
always_ff @(posedge clock)
begin
    if (!rst_n)
    begin
        map_high_r <= vpqm_pkg::VPQM_RST_MAP_HIGH;
    end
    else if (wr_map_high)
    begin
        map_high_r <= reg_wdata;
    end
end

// Two-queue split field; other bits of this register are fixed
always_ff @(posedge clock)
begin
    if (!rst_n)
    begin
        two_queue_split_select_r <= vpqm_pkg::VPQM_RST_SPLIT;
    end
    else if (wr_fold)
    begin
        two_queue_split_select_r <= reg_wdata[vpqm_pkg::VPQM_SPLIT_LSB +: vpqm_pkg::VPQM_FIELD_W];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read back; reserved fold bits show fixed values
always_comb
begin
    reg_rdata_nxt = vpqm_pkg::VPQM_RDATA_NONE;
    case (reg_addr)
        vpqm_pkg::VPQM_ADDR_MAP_LOW:
        begin
            reg_rdata_nxt = map_low_r;
        end
        vpqm_pkg::VPQM_ADDR_MAP_HIGH:
        begin
            reg_rdata_nxt = map_high_r;
        end
        vpqm_pkg::VPQM_ADDR_FOLD:
        begin
            reg_rdata_nxt = {two_queue_split_select_r, vpqm_pkg::VPQM_RST_FOLD_RSVD_TOP,
                vpqm_pkg::VPQM_RST_FOLD_RSVD_MID, vpqm_pkg::VPQM_RST_FOLD_RSVD_HI};
        end
        default:
        begin
            reg_rdata_nxt = vpqm_pkg::VPQM_RDATA_NONE;
        end
    endcase
end

// Read data register; follows the address one cycle later
always_ff @(posedge clock)
begin
    if (!rst_n)
    begin
        reg_rdata_r <= vpqm_pkg::VPQM_RDATA_NONE;
    end
    else
    begin
        reg_rdata_r <= reg_rdata_nxt;
    end
end

assign reg_rdata = reg_rdata_r;

////////////////////////////////////////////////////////////////////////////////
// Field lookup
assign map_all = {map_high_r, map_low_r};

genvar gi;
generate
    for (gi = 0; gi < vpqm_pkg::VPQM_PCP_COUNT; gi++)
    begin : g_field
        assign pcp_queue_field[gi] = map_all[gi*vpqm_pkg::VPQM_FIELD_W +: vpqm_pkg::VPQM_FIELD_W];
    end
endgenerate

// Source of the four-level result
always_comb
begin
    if (req.use_dscp)
    begin
        mapped = req.dscp_queue;
    end
    else
    begin
        mapped = pcp_queue_field[req.pcp];
    end
end

// Two-queue fold
always_comb
begin
    case (mapped)
        vpqm_pkg::VPQM_Q_LOWEST:
        begin
            fold_high = 1'b0;
        end
        vpqm_pkg::VPQM_Q_MID_LOW:
        begin
            fold_high = two_queue_split_select_r[0];
        end
        vpqm_pkg::VPQM_Q_MID_HIGH:
        begin
            fold_high = two_queue_split_select_r[1];
        end
        vpqm_pkg::VPQM_Q_HIGHEST:
        begin
            fold_high = 1'b1;
        end
        default:
        begin
            fold_high = 1'b0;
        end
    endcase
end

// Next result
always_comb
begin
    res_nxt.valid = req.valid;
    res_nxt.queue = mapped;
    res_nxt.two_q_high = two_queue_mode & fold_high;
end

////////////////////////////////////////////////////////////////////////////////
// Result valid; stands one cycle per request
always_ff @(posedge clock)
begin
    if (!rst_n)
    begin
        res_valid_r <= 1'b0;
    end
    else
    begin
        res_valid_r <= res_nxt.valid;
    end
end

// Queue number; held until the next request
always_ff @(posedge clock)
begin
    if (!rst_n)
    begin
        res_queue_r <= vpqm_pkg::VPQM_Q_LOWEST;
    end
    else if (req.valid)
    begin
        res_queue_r <= res_nxt.queue;
    end
end

// Two-queue side; held until the next request
always_ff @(posedge clock)
begin
    if (!rst_n)
    begin
        res_high_r <= 1'b0;
    end
    else if (req.valid)
    begin
        res_high_r <= res_nxt.two_q_high;
    end
end

assign res = '{valid: res_valid_r, queue: res_queue_r, two_q_high: res_high_r};

endmodule

//--- sim/vpqm_mapper_sva.sv
// Checker for the priority queue mapper
module vpqm_mapper_sva
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic two_queue_mode,
    input vpqm_pkg::vpqm_req_t req,
    input vpqm_pkg::vpqm_res_t res
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [2:0] pcp_r;
    always_ff @(posedge clock) pcp_r <= req.pcp;
    wire [1:0] fld = reg_rdata[2*pcp_r[1:0] +: 2];
    property p_vld; res.valid == $past(req.valid); endproperty
    a_vld: assert property (p_vld) else $error("valid");
    property p_map; req.valid && !req.use_dscp && reg_addr == {7'h40, req.pcp[2]} |=> res.queue == fld; endproperty
    a_map: assert property (p_map) else $error("queue");
    property p_dsc; req.valid && req.use_dscp |=> res.queue == $past(req.dscp_queue); endproperty
    a_dsc: assert property (p_dsc) else $error("source");
    property p_off; res.valid && !$past(two_queue_mode) |-> !res.two_q_high; endproperty
    a_off: assert property (p_off) else $error("fold");
    property p_end; res.valid && $past(two_queue_mode) && res.queue inside {0, 3} |-> res.two_q_high == res.queue[0]; endproperty
    a_end: assert property (p_end) else $error("ends");
    property p_spl; req.valid && two_queue_mode && reg_addr == 8'h82 ##1 res.queue inside {1, 2}
        |-> res.two_q_high == (res.queue[0] ? reg_rdata[6] : reg_rdata[7]); endproperty
    a_spl: assert property (p_spl) else $error("split");
endmodule
bind vpqm_mapper vpqm_mapper_sva u_vpqm_mapper_sva (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .two_queue_mode(two_queue_mode), .req(req), .res(res));

//--- sim/vpqm_mapper_tb.sv
// Testbench for the priority queue mapper
module vpqm_mapper_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, rst_n = 0, reg_wr = 0, two_queue_mode = 0;
    logic [7:0] reg_addr = 8'h80, reg_wdata = 8'h00, reg_rdata;
    vpqm_pkg::vpqm_req_t req = '0;
    vpqm_pkg::vpqm_res_t res;
    int err_count = 0, n_tests = 0, cyc_n = 0;
    vpqm_mapper u_vpqm_mapper (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .two_queue_mode(two_queue_mode), .req(req), .res(res));
    initial forever #10 clock = ~clock;
    always @(posedge clock) if (++cyc_n > 2000) begin err_count++; finish_test(); end
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        n_tests++;
        if (s !== e) begin err_count++; $display("unexpected %s expected %h seen %h", n, e, s); end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock) reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        chk("rdata", e, reg_rdata);
    endtask
    task automatic cls(logic u, logic [2:0] p, logic [1:0] d, logic [1:0] q, logic h);
        req <= {1'b1, u, p, d};
        @(posedge clock) req <= '0;
        @(posedge clock) chk("res", {1'b1, q, h}, res);
    endtask
    task automatic t_reset();
        rd(8'h80, 8'h50);
        rd(8'h81, 8'hfa);
        rd(8'h82, 8'h84);
        for (int p = 0; p < 8; p++) cls(0, p, 0, p >> 1, 0);
    endtask
    task automatic t_map();
        wr(8'h81, 8'he4);
        wr(8'h80, 8'h1b);
        for (int p = 0; p < 8; p++) cls(0, p, 0, p < 4 ? 3 - p : p - 4, 0);
        req <= {1'b1, 1'b0, 3'h1, 2'h0};
        reg_addr <= 8'h80;
        reg_wdata <= 8'hff;
        reg_wr <= 1'b1;
        @(posedge clock) req <= '0;
        reg_wr <= 1'b0;
        @(posedge clock) chk("old", 8'h0c, res);
        cls(0, 1, 0, 3, 0);
    endtask
    task automatic t_fold(logic [1:0] s);
        two_queue_mode <= 1'b1;
        wr(8'h82, {s, 6'h3f});
        rd(8'h82, {s, 6'h04});
        for (int r = 0; r < 4; r++) cls(1, 0, r, r, r == 3 || (r == 1 && s[0]) || (r == 2 && s[1]));
        two_queue_mode <= 1'b0;
        cls(1, 0, 2, 2, 0);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_map();
        t_fold(2'h0);
        t_fold(2'h2);
        t_fold(2'h3);
        finish_test();
    end
endmodule
